// ===== hw/asr_pkg.sv
package asr_pkg;
  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // ==========================================================
  // Clock and intervals in ns, fastest grade
  localparam int CLK_NS = 10;
  localparam int READ_CYCLE_MIN_NS = 70;
  localparam int WRITE_CYCLE_MIN_NS = 70;
  localparam int WRITE_OVERLAP_MIN_NS = 55;
  localparam int DATA_SETUP_NS = 30;
  localparam int CS_FLOAT_NS = 25;
  localparam int OE_FLOAT_NS = 25;
  localparam int RECOVERY_AFTER_WE_NS = 5;
  localparam int CS_TO_END_MIN_NS = 65;
  localparam int ADDR_TO_END_MIN_NS = 65;
  // ==========================================================
  // Cycle counts, rounded up
  localparam int READ_CYC = (READ_CYCLE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (WRITE_OVERLAP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DS_CYC = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC0 = (RECOVERY_AFTER_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (WR_CYC0 < 1) ? 1 : WR_CYC0;
  localparam int FLT0 = (CS_FLOAT_NS > OE_FLOAT_NS) ? CS_FLOAT_NS : OE_FLOAT_NS;
  localparam int FLOAT_CYC = (FLT0 + CLK_NS - 1) / CLK_NS;
  localparam int WC_CYC = (WRITE_CYCLE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CW_CYC = (CS_TO_END_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int AW_CYC = (ADDR_TO_END_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WLOW1 = (WP_CYC > DS_CYC) ? WP_CYC : DS_CYC;
  localparam int WLOW2 = (CW_CYC > AW_CYC) ? CW_CYC : AW_CYC;
  localparam int WLOW0 = (WLOW1 > WLOW2) ? WLOW1 : WLOW2;
  localparam int WLOW_CYC = (WLOW0 + WR_CYC > WC_CYC) ? WLOW0 : WC_CYC - WR_CYC;
  localparam int CNT_W = 4;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_FLOAT = 3'b010,
    ST_WRITE = 3'b011,
    ST_RECOV = 3'b100
  } asr_state_t;
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
  } asr_strobe_t;
  localparam asr_strobe_t STROBE_IDLE = 3'b111;
endpackage

// ===== hw/asr_host.sv
// What this block does
// - Write enable stays high during reads
// - Read data sampled after cycle minimum
// - Address registered on the same edge where chip select falls
// - Write spans overlap of both strobes
// - Write ends at first rising strobe
// - Chip select low long enough
// - Address held through write end
// - Overlap lasts write_overlap_min
// - Recovery after write enable rises
// - Data set up before strobe rises
// - Address changes only with strobe high
// - No host drive while output enable low
`timescale 1ns/10ps
`default_nettype none
module asr_host
  import asr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] word_address,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);
  // ==========================================================
  // State
  asr_state_t state;
  asr_strobe_t strb;
  logic [CNT_W-1:0] cnt;
  logic float_done;

  // ==========================================================
  // Decode
  wire logic cnt_zero = (cnt == '0);
  wire logic take = ce && req_ready && req_valid;
  wire logic [CNT_W-1:0] cnt_dec = cnt - 4'h1;

  assign chip_select_n = strb.cs_n;
  assign output_enable_n = strb.oe_n;
  assign write_enable_n = strb.we_n;

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      strb <= STROBE_IDLE;
      cnt <= '0;
      float_done <= 1'b1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      word_address <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (take) begin
            req_ready <= 1'b0;
            word_address <= req_addr;
            if (req_write) begin
              if (float_done) begin
                // select and write together, output enable stays high
                strb <= '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
                data_out <= req_wdata;
                data_oe <= 1'b1;
                cnt <= CNT_W'(WLOW_CYC - 1);
                state <= ST_WRITE;
              end else begin
                cnt <= CNT_W'(FLOAT_CYC - 1);
                data_out <= req_wdata;
                state <= ST_FLOAT;
              end
            end else begin
              strb <= '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
              cnt <= CNT_W'(READ_CYC - 1);
              state <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (cnt_zero) begin
            rsp_rdata <= data_in;
            rsp_valid <= 1'b1;
            strb <= STROBE_IDLE;
            float_done <= 1'b0;
            cnt <= CNT_W'(FLOAT_CYC - 1);
            state <= ST_RECOV;
          end else begin
            cnt <= cnt_dec;
          end
        end
        ST_FLOAT: begin
          if (cnt_zero) begin
            float_done <= 1'b1;
            strb <= '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
            data_oe <= 1'b1;
            cnt <= CNT_W'(WLOW_CYC - 1);
            state <= ST_WRITE;
          end else begin
            cnt <= cnt_dec;
          end
        end
        ST_WRITE: begin
          if (cnt_zero) begin
            strb.we_n <= 1'b1;
            cnt <= CNT_W'(WR_CYC - 1);
            state <= ST_RECOV;
          end else begin
            cnt <= cnt_dec;
          end
        end
        ST_RECOV: begin
          if (strb.cs_n == 1'b0) begin
            strb.cs_n <= 1'b1;
            data_oe <= 1'b0;
          end
          if (cnt_zero) begin
            float_done <= 1'b1;
            req_ready <= 1'b1;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt_dec;
          end
        end
        default: begin
          state <= ST_IDLE;
          strb <= STROBE_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  logic [CNT_W-1:0] low_run;
  always_ff @(posedge clk_sys) begin
    if (rst || write_enable_n || chip_select_n) begin
      low_run <= '0;
    end else if (ce && low_run != 4'hf) begin
      low_run <= low_run + 4'h1;
    end
  end

  sequence s_write_end;
    $rose(write_enable_n) && !chip_select_n;
  endsequence

  property p_read_we_high;
    @(posedge clk_sys) disable iff (rst) !output_enable_n |-> write_enable_n;
  endproperty
  a_read_we_high: assert property (p_read_we_high) else $error("we low in read");

  property p_read_len;
    @(posedge clk_sys) disable iff (rst) rsp_valid |-> $past(state) == ST_READ;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read answer early");

  property p_overlap;
    @(posedge clk_sys) disable iff (rst) s_write_end |-> low_run >= CNT_W'(WP_CYC - 1);
  endproperty
  a_overlap: assert property (p_overlap) else $error("write overlap short");

  property p_addr_stable;
    @(posedge clk_sys) disable iff (rst)
      !$stable(word_address) |-> $past(chip_select_n) || $past(write_enable_n);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("addr moved in write");

  property p_no_contention;
    @(posedge clk_sys) disable iff (rst) data_oe |-> output_enable_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

  property p_recovery;
    @(posedge clk_sys) disable iff (rst) s_write_end |=> chip_select_n;
  endproperty
  a_recovery: assert property (p_recovery) else $error("no recovery");

  property p_data_hold;
    @(posedge clk_sys) disable iff (rst) s_write_end |-> data_oe && $stable(data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held");

  property p_turnaround;
    @(posedge clk_sys) disable iff (rst)
      $rose(output_enable_n) |-> !data_oe [*2];
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("turnaround short");

  // ==========================================================
  // Further strobe, address, data and response checks
  sequence s_read_hold;
    !output_enable_n [*7];
  endsequence

  sequence s_selected;
    !chip_select_n && !$fell(chip_select_n);
  endsequence

  property p_read_hold;
    @(posedge clk_sys) disable iff (rst)
      $fell(output_enable_n) |-> s_read_hold;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read cycle short");

  property p_rsp_pulse;
    @(posedge clk_sys) disable iff (rst)
      rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");

  property p_addr_selected;
    @(posedge clk_sys) disable iff (rst)
      s_selected |-> $stable(word_address);
  endproperty
  a_addr_selected: assert property (p_addr_selected) else $error("addr moved selected");

  property p_we_with_cs;
    @(posedge clk_sys) disable iff (rst)
      !write_enable_n |-> !chip_select_n;
  endproperty
  a_we_with_cs: assert property (p_we_with_cs) else $error("write without select");

  property p_write_oe_high;
    @(posedge clk_sys) disable iff (rst)
      !write_enable_n |-> output_enable_n;
  endproperty
  a_write_oe_high: assert property (p_write_oe_high) else $error("oe low in write");

  property p_we_ends_first;
    @(posedge clk_sys) disable iff (rst)
      $rose(chip_select_n) |-> write_enable_n && !$rose(write_enable_n);
  endproperty
  a_we_ends_first: assert property (p_we_ends_first) else $error("cs ended write");

  property p_cs_len;
    @(posedge clk_sys) disable iff (rst)
      s_write_end |-> low_run >= CNT_W'(CW_CYC - 1);
  endproperty
  a_cs_len: assert property (p_cs_len) else $error("select short");

  property p_addr_len;
    @(posedge clk_sys) disable iff (rst)
      s_write_end |-> low_run >= CNT_W'(AW_CYC - 1) && $stable(word_address);
  endproperty
  a_addr_len: assert property (p_addr_len) else $error("addr short");

  property p_recov_we;
    @(posedge clk_sys) disable iff (rst)
      s_write_end |=> write_enable_n && !data_oe;
  endproperty
  a_recov_we: assert property (p_recov_we) else $error("recovery broken");

  property p_data_setup;
    @(posedge clk_sys) disable iff (rst)
      s_write_end |-> $past(data_oe, DS_CYC) && $stable(data_out);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("data setup short");

  property p_float_first;
    @(posedge clk_sys) disable iff (rst)
      $rose(data_oe) |-> $past(output_enable_n, FLOAT_CYC) && $past(output_enable_n);
  endproperty
  a_float_first: assert property (p_float_first) else $error("drive before float");

  property p_reset_idle;
    @(posedge clk_sys)
      rst |=> chip_select_n && output_enable_n && write_enable_n && !data_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("strobes not idle");

  property p_ready_idle;
    @(posedge clk_sys) disable iff (rst)
      req_ready |-> chip_select_n && output_enable_n && write_enable_n;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready while busy");
endmodule
`default_nettype wire

// ===== testbench/asr_sram_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Byte-wide static memory, behavioural
module asr_sram_model
  import asr_pkg::*;
(
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic slow,
  output logic [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] a_last = '0;
  logic [ADDR_W-1:0] wa = '0;
  logic [DATA_W-1:0] wd = '0;
  logic pend = 1'b0;
  logic act = 1'b0;
  realtime t_go = 0;
  initial data_in = 8'h5a;
  // ====
  // Access, float and write capture
  always begin
    #0.5;
    act = !chip_select_n && !output_enable_n && write_enable_n;
    if (!act || word_address != a_last) t_go = $realtime;
    a_last = word_address;
    if (act && $realtime - t_go >= (slow ? 69 : 20)) data_in = mem[word_address];
    else data_in = ~data_in;
    if (!chip_select_n && !write_enable_n) begin
      wa = word_address;
      wd = data_oe ? data_out : ~data_out;
      pend = 1'b1;
    end else if (pend) begin
      mem[wa] = wd;
      pend = 1'b0;
    end
    #0.5;
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import asr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic slow = 1'b1;
  logic req_ready, rsp_valid, chip_select_n, output_enable_n, write_enable_n, data_oe;
  logic [DATA_W-1:0] rsp_rdata, data_in, data_out;
  logic [ADDR_W-1:0] word_address;
  logic [ADDR_W-1:0] prev_a = '0;
  logic prev_free = 1'b1;
  logic [ADDR_W-1:0] ta [3] = '{17'h00000, 17'h1ffff, 17'h0aaaa};
  logic [DATA_W-1:0] td [3] = '{8'ha5, 8'h3c, 8'h00};
  int n_errors = 0;
  int n_checks = 0;
  int idle = 100;
  always #5 clk_sys = ~clk_sys;
  asr_host uut (.clk_sys, .rst, .ce, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .word_address, .chip_select_n, .output_enable_n,
    .write_enable_n, .data_in, .data_out, .data_oe);
  asr_sram_model mem_model (.word_address, .chip_select_n, .output_enable_n,
    .write_enable_n, .data_out, .data_oe, .slow, .data_in);
  // ====
  // Compare and verdict
  task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // Pin monitor
  always @(negedge clk_sys) if (!rst) begin
    if (output_enable_n === 1'b0) chk(17'(write_enable_n), 17'h1);
    if (data_oe === 1'b1) chk(17'(output_enable_n), 17'h1);
    if (word_address !== prev_a) chk(17'(prev_free), 17'h1);
    if (output_enable_n !== 1'b1) idle = 0;
    else if (data_oe !== 1'b1) idle++;
    else chk(17'(idle >= FLOAT_CYC), 17'h1);
    prev_a = word_address;
    prev_free = chip_select_n | write_enable_n;
  end
  // ====
  // One request, judged
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 40) begin
      n_errors++;
      tally_and_finish();
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 1;
    while (((w && write_enable_n === 1'b0) || (!w && rsp_valid !== 1'b1)) && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 40) n_errors++;
    if (w) begin
      chk(17'(n - 1), 17'(WLOW_CYC));
      chk(17'({chip_select_n, data_oe}), 17'h1);
    end else begin
      chk(17'(n), 17'(READ_CYC + 1));
      chk(17'(rsp_rdata), 17'(d));
    end
  endtask
  // ====
  // Scenarios
  task automatic sc_reset();
    repeat (12) @(negedge clk_sys);
    chk({14'h0, chip_select_n, output_enable_n, write_enable_n}, 17'h7);
    chk({15'h0, data_oe, req_ready}, 17'h0);
    rst = 1'b0;
  endtask
  task automatic sc_fill();
    for (int i = 0; i < 3; i++) req(1'b1, ta[i], td[i]);
  endtask
  task automatic sc_readback(input logic s);
    slow = s;
    for (int i = 0; i < 3; i++) req(1'b0, ta[i], td[i]);
  endtask
  task automatic sc_turn();
    req(1'b0, ta[1], td[1]);
    req(1'b1, ta[1], 8'h96);
    req(1'b0, ta[1], 8'h96);
  endtask
  task automatic sc_freeze();
    @(negedge clk_sys);
    ce = 1'b0;
    req_valid = 1'b1;
    req_write = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk(17'(chip_select_n), 17'h1);
    ce = 1'b1;
    req_valid = 1'b0;
    req(1'b0, ta[0], td[0]);
  endtask
  initial begin
    sc_reset();
    sc_fill();
    sc_readback(1'b1);
    sc_readback(1'b0);
    sc_turn();
    sc_freeze();
    tally_and_finish();
  end
endmodule
`default_nettype wire
